// ### design/channel_param_io.sv
`timescale 1ns/1ps
`default_nettype none
`include "channel_param_defs.svh"

module channel_param_io (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // avalon-mm slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // parameter record write from the controller
    input wire logic recValid,
    input wire logic [15:0] recIndex,
    input wire logic recToOutput,
    input wire logic [23:0] recData,
    output logic recDone,
    output logic recAccepted,
    // controller association and output process data
    input wire logic assocUp,
    input wire logic providerRun,
    input wire logic outValid,
    input wire logic [`NUM_CH-1:0] outData,
    output logic [`NUM_CH-1:0] outPins,
    // field input pins
    input wire logic [`NUM_CH-1:0] inPins,
    input wire logic [`NUM_CH-1:0] chanErrPins,
    input wire logic [`NUM_CH-1:0] extFaultPins,
    output logic [`NUM_CH-1:0] inReport,
    // diagnostic alarm stream
    output logic alarmValid,
    output logic [`CH_IDX_W-1:0] alarmChan,
    output logic alarmExternal
);

    // control and parameter state
    logic diagCapable_r;
    logic stationHold_r;
    logic [`NUM_CH-1:0] diagEn_r;
    logic [`NUM_CH-1:0] extEn_r;
    logic [`NUM_CH-1:0] invert_r;
    channel_param_pkg::policy_t policy_r;
    logic [`NUM_CH-1:0] subst_r;

    // record handshake and sticky status
    logic recOk;
    logic recDone_r;
    logic recAccepted_r;
    logic stReject_r;
    logic stAccept_r;

    // missing-data tracking
    logic missing_r;
    logic providerRunPrev_r;

    // input synchronisers
    logic [`NUM_CH-1:0] inMeta_r;
    logic [`NUM_CH-1:0] inSync_r;
    logic [`NUM_CH-1:0] errMeta_r;
    logic [`NUM_CH-1:0] errSync_r;
    logic [`NUM_CH-1:0] extMeta_r;
    logic [`NUM_CH-1:0] extSync_r;
    logic [`NUM_CH-1:0] errPrev_r;
    logic [`NUM_CH-1:0] extPrev_r;
    logic [`NUM_CH-1:0] inReport_r;

    // alarm queue
    logic [`NUM_CH-1:0] errPend_r;
    logic [`NUM_CH-1:0] extPend_r;
    logic [`NUM_CH-1:0] errNew;
    logic [`NUM_CH-1:0] extNew;
    logic [`NUM_CH-1:0] errTake;
    logic [`NUM_CH-1:0] extTake;
    logic pickValid;
    logic pickExt;
    logic [`CH_IDX_W-1:0] pickChan;
    logic alarmValid_r;
    logic [`CH_IDX_W-1:0] alarmChan_r;
    logic alarmExternal_r;
    logic [15:0] logCount_r;

    // bus slave
    logic waitrequest_r;
    logic [31:0] readdata_r;
    logic [31:0] readdata_nxt;
    logic busReq;
    logic busDone;
    logic ctrlWr;
    logic statusWr;
    logic [`NUM_CH-1:0] outDrive;

    // record acceptance: right index and a module able to take it
    always_comb begin
        recOk = 1'b0;
        if (recIndex == `REC_INDEX) begin
            if (recToOutput) begin
                recOk = 1'b1;
            end else begin
                recOk = diagCapable_r;
            end
        end
    end

    // record answer, one cycle after the request
    always_ff @(posedge core_clk) begin
        if (reset) begin
            recDone_r <= 1'b0;
            recAccepted_r <= 1'b0;
        end else begin
            recDone_r <= recValid;
            recAccepted_r <= recValid && recOk;
        end
    end

    // input record: per-channel attributes
    always_ff @(posedge core_clk) begin
        if (reset) begin
            diagEn_r <= `PARAM_BYTE_RESET;
            extEn_r <= `PARAM_BYTE_RESET;
            invert_r <= `PARAM_BYTE_RESET;
        end else if (recValid && recOk && !recToOutput) begin
            diagEn_r <= recData[`DIAGEN_LSB +: `NUM_CH];
            extEn_r <= recData[`EXTEN_LSB +: `NUM_CH];
            invert_r <= recData[`INVERT_LSB +: `NUM_CH];
        end
    end

    // output record: policy and substitute byte
    always_ff @(posedge core_clk) begin
        if (reset) begin
            policy_r <= channel_param_pkg::POL_DEVICE;
            subst_r <= `PARAM_BYTE_RESET;
        end else if (recValid && recOk && recToOutput) begin
            policy_r <= channel_param_pkg::policy_t'(
                recData[`POLICY_LSB +: 2]);
            subst_r <= recData[`SUBST_LSB +: `NUM_CH];
        end
    end

    // missing data: association lost or provider run to stop
    always_ff @(posedge core_clk) begin
        if (reset) begin
            missing_r <= 1'b1;
            providerRunPrev_r <= 1'b0;
        end else begin
            providerRunPrev_r <= providerRun;
            if (!assocUp || (providerRunPrev_r && !providerRun)) begin
                missing_r <= 1'b1;
            end else if (providerRun && outValid) begin
                missing_r <= 1'b0;
            end
        end
    end

    // output drive stage per channel
    output_substitute u_outsub (
        .core_clk(core_clk),
        .reset(reset),
        .missing(missing_r),
        .dataValid(outValid && providerRun && assocUp),
        .outData(outData),
        .policy(policy_r),
        .subst(subst_r),
        .stationHold(stationHold_r),
        .outDrive(outDrive)
    );

    // register the drive once more so the pins sit on a flop here
    always_ff @(posedge core_clk) begin
        if (reset) begin
            outPins <= `PARAM_BYTE_RESET;
        end else begin
            outPins <= outDrive;
        end
    end

    // field pins pass two flip-flops
    always_ff @(posedge core_clk) begin
        if (reset) begin
            inMeta_r <= `PARAM_BYTE_RESET;
            inSync_r <= `PARAM_BYTE_RESET;
            errMeta_r <= `PARAM_BYTE_RESET;
            errSync_r <= `PARAM_BYTE_RESET;
            extMeta_r <= `PARAM_BYTE_RESET;
            extSync_r <= `PARAM_BYTE_RESET;
        end else begin
            inMeta_r <= inPins;
            inSync_r <= inMeta_r;
            errMeta_r <= chanErrPins;
            errSync_r <= errMeta_r;
            extMeta_r <= extFaultPins;
            extSync_r <= extMeta_r;
        end
    end

    // reported input level, complemented where asked
    always_ff @(posedge core_clk) begin
        if (reset) begin
            inReport_r <= `PARAM_BYTE_RESET;
        end else begin
            inReport_r <= inSync_r
                ^ (invert_r & {`NUM_CH{diagCapable_r}});
        end
    end

    // fault onsets, filtered by the released diagnostics
    always_ff @(posedge core_clk) begin
        if (reset) begin
            errPrev_r <= `PARAM_BYTE_RESET;
            extPrev_r <= `PARAM_BYTE_RESET;
        end else begin
            errPrev_r <= errSync_r;
            extPrev_r <= extSync_r;
        end
    end
    assign errNew = errSync_r & ~errPrev_r & diagEn_r;
    assign extNew = extSync_r & ~extPrev_r & diagEn_r & extEn_r;

    // pick the lowest pending channel, channel errors first
    always_comb begin
        pickValid = 1'b0;
        pickExt = 1'b0;
        pickChan = '0;
        errTake = '0;
        extTake = '0;
        for (int i = `NUM_CH - 1; i >= 0; i--) begin
            if (extPend_r[i] && diagEn_r[i] && extEn_r[i]) begin
                pickValid = 1'b1;
                pickExt = 1'b1;
                pickChan = i[`CH_IDX_W-1:0];
            end
        end
        for (int i = `NUM_CH - 1; i >= 0; i--) begin
            if (errPend_r[i] && diagEn_r[i]) begin
                pickValid = 1'b1;
                pickExt = 1'b0;
                pickChan = i[`CH_IDX_W-1:0];
            end
        end
        if (pickValid && pickExt) begin
            extTake[pickChan] = 1'b1;
        end
        if (pickValid && !pickExt) begin
            errTake[pickChan] = 1'b1;
        end
    end

    // pending alarms: a new onset wins over the taking
    always_ff @(posedge core_clk) begin
        if (reset) begin
            errPend_r <= `PARAM_BYTE_RESET;
            extPend_r <= `PARAM_BYTE_RESET;
        end else begin
            errPend_r <= (errPend_r & ~errTake & diagEn_r) | errNew;
            extPend_r <= (extPend_r & ~extTake & diagEn_r & extEn_r)
                | extNew;
        end
    end

    // alarm emission and log entry
    always_ff @(posedge core_clk) begin
        if (reset) begin
            alarmValid_r <= 1'b0;
            alarmChan_r <= '0;
            alarmExternal_r <= 1'b0;
            logCount_r <= `LOG_CNT_RESET;
        end else begin
            alarmValid_r <= pickValid;
            if (pickValid) begin
                alarmChan_r <= pickChan;
                alarmExternal_r <= pickExt;
                logCount_r <= logCount_r + 16'h0001;
            end
        end
    end

    // bus request decode
    assign busReq = read || write;
    assign busDone = busReq && !waitrequest_r;
    assign ctrlWr = busDone && write && (address == `REG_CTRL)
        && byteenable[0];
    assign statusWr = busDone && write && (address == `REG_STATUS)
        && byteenable[0];

    // one wait cycle per access, then release for one cycle
    always_ff @(posedge core_clk) begin
        if (reset) begin
            waitrequest_r <= 1'b1;
        end else begin
            waitrequest_r <= !(busReq && waitrequest_r);
        end
    end

    // control register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            {stationHold_r, diagCapable_r} <= `CTRL_RESET;
        end else if (ctrlWr) begin
            diagCapable_r <= writedata[`CTRL_DIAGCAP_BIT];
            stationHold_r <= writedata[`CTRL_HOLD_BIT];
        end
    end

    // sticky record status, set wins over write-one-to-clear
    always_ff @(posedge core_clk) begin
        if (reset) begin
            stReject_r <= 1'b0;
            stAccept_r <= 1'b0;
        end else begin
            if (recValid && !recOk) begin
                stReject_r <= 1'b1;
            end else if (statusWr && writedata[`ST_REJECT_BIT]) begin
                stReject_r <= 1'b0;
            end
            if (recValid && recOk) begin
                stAccept_r <= 1'b1;
            end else if (statusWr && writedata[`ST_ACCEPT_BIT]) begin
                stAccept_r <= 1'b0;
            end
        end
    end

    // read mux, unmapped offsets read zero
    always_comb begin
        readdata_nxt = `WORD_ZERO;
        unique case (address)
            `REG_CTRL: begin
                readdata_nxt[`CTRL_DIAGCAP_BIT] = diagCapable_r;
                readdata_nxt[`CTRL_HOLD_BIT] = stationHold_r;
            end
            `REG_IN_PARAM: begin
                readdata_nxt[`DIAGEN_LSB +: `NUM_CH] = diagEn_r;
                readdata_nxt[`EXTEN_LSB +: `NUM_CH] = extEn_r;
                readdata_nxt[`INVERT_LSB +: `NUM_CH] = invert_r;
            end
            `REG_OUT_PARAM: begin
                readdata_nxt[`POLICY_LSB +: 2] = policy_r;
                readdata_nxt[`SUBST_LSB +: `NUM_CH] = subst_r;
            end
            `REG_STATUS: begin
                readdata_nxt[`ST_REJECT_BIT] = stReject_r;
                readdata_nxt[`ST_ACCEPT_BIT] = stAccept_r;
                readdata_nxt[`ST_MISSING_BIT] = missing_r;
            end
            `REG_LOG: begin
                readdata_nxt[`LOG_CNT_LSB +: 16] = logCount_r;
                readdata_nxt[`LOG_CHAN_LSB +: `CH_IDX_W] = alarmChan_r;
                readdata_nxt[`LOG_EXT_BIT] = alarmExternal_r;
            end
            default: begin
                readdata_nxt = `WORD_ZERO;
            end
        endcase
    end

    // read data captured as waitrequest drops
    always_ff @(posedge core_clk) begin
        if (reset) begin
            readdata_r <= `WORD_ZERO;
        end else if (read && waitrequest_r) begin
            readdata_r <= readdata_nxt;
        end
    end

    // outputs from flops
    assign readdata = readdata_r;
    assign waitrequest = waitrequest_r;
    assign recDone = recDone_r;
    assign recAccepted = recAccepted_r;
    assign inReport = inReport_r;
    assign alarmValid = alarmValid_r;
    assign alarmChan = alarmChan_r;
    assign alarmExternal = alarmExternal_r;

endmodule // channel_param_io

`default_nettype wire

// ### design/channel_param_defs.svh
`ifndef CHANNEL_PARAM_DEFS_SVH
`define CHANNEL_PARAM_DEFS_SVH

// channel count and record addressing
`define NUM_CH 8
`define CH_IDX_W 3
`define REC_INDEX 16'h4000

// register byte offsets
`define REG_CTRL 8'h00
`define REG_IN_PARAM 8'h04
`define REG_OUT_PARAM 8'h08
`define REG_STATUS 8'h0C
`define REG_LOG 8'h10

// control register fields
`define CTRL_DIAGCAP_BIT 0
`define CTRL_HOLD_BIT 1
`define CTRL_RESET 2'h0

// parameter field positions (record data and registers)
`define DIAGEN_LSB 0
`define EXTEN_LSB 8
`define INVERT_LSB 16
`define POLICY_LSB 0
`define SUBST_LSB 8

// status register bits
`define ST_REJECT_BIT 0
`define ST_ACCEPT_BIT 1
`define ST_MISSING_BIT 2

// log register fields
`define LOG_CNT_LSB 0
`define LOG_CHAN_LSB 16
`define LOG_EXT_BIT 19

// reset values
`define PARAM_BYTE_RESET 8'h00
`define LOG_CNT_RESET 16'h0000
`define WORD_ZERO 32'h00000000

`endif

// ### design/channel_param_pkg.sv
package channel_param_pkg;

    // missing-data policy of an output module
    typedef enum logic [1:0] {
        POL_DEVICE = 2'h0,
        POL_KEEP = 2'h1,
        POL_SUBST = 2'h2
    } policy_t;

endpackage

// ### design/output_substitute.sv
`timescale 1ns/1ps
`default_nettype none
`include "channel_param_defs.svh"

module output_substitute (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // process data from the controller
    input wire logic missing,
    input wire logic dataValid,
    input wire logic [`NUM_CH-1:0] outData,
    // parameters
    input wire channel_param_pkg::policy_t policy,
    input wire logic [`NUM_CH-1:0] subst,
    input wire logic stationHold,
    // driven channel levels
    output logic [`NUM_CH-1:0] outDrive
);

    logic [`NUM_CH-1:0] lastValid_r;

    // remember the last process value that arrived while data was good
    always_ff @(posedge core_clk) begin
        if (reset) begin
            lastValid_r <= `PARAM_BYTE_RESET;
        end else if (dataValid && !missing) begin
            lastValid_r <= outData;
        end
    end

    // one drive stage per channel
    genvar ch;
    generate
        for (ch = 0; ch < `NUM_CH; ch = ch + 1) begin : g_ch
            always_ff @(posedge core_clk) begin
                if (reset) begin
                    outDrive[ch] <= 1'b0;
                end else if (missing) begin
                    unique case (policy)
                        channel_param_pkg::POL_KEEP: begin
                            outDrive[ch] <= lastValid_r[ch];
                        end
                        channel_param_pkg::POL_SUBST: begin
                            outDrive[ch] <= subst[ch];
                        end
                        default: begin
                            // station-wide: hold or drop to zero
                            outDrive[ch] <= stationHold
                                & lastValid_r[ch];
                        end
                    endcase
                end else if (dataValid) begin
                    outDrive[ch] <= outData[ch];
                end
            end
        end
    endgenerate

endmodule // output_substitute

`default_nettype wire

// ### tb/channel_param_io_props.sv
`timescale 1ns/1ps
`default_nettype none
module channel_param_io_props (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // register bus
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic waitrequest,
    // record port
    input wire logic recValid,
    input wire logic [15:0] recIndex,
    input wire logic recToOutput,
    input wire logic [23:0] recData,
    input wire logic recDone,
    input wire logic recAccepted,
    // process data and alarms
    input wire logic assocUp,
    input wire logic providerRun,
    input wire logic outValid,
    input wire logic [7:0] outData,
    input wire logic [7:0] outPins,
    input wire logic alarmValid,
    input wire logic [2:0] alarmChan,
    input wire logic alarmExternal
);
    logic diagCap_r;
    logic [7:0] diagEn_r, extEn_r, diagOld_r, extOld_r, lastOut_r;
    wire logic run = assocUp && providerRun;
    wire logic inTake = recValid && recIndex == 16'h4000 && !recToOutput
        && diagCap_r;
    // enables of this cycle or the one before, since pending alarms lag
    wire logic [7:0] enAny = diagEn_r | diagOld_r;
    wire logic [7:0] extAny = extEn_r | extOld_r;

    // mirror of the capability bit, input enables and newest process value
    always_ff @(posedge core_clk) begin
        if (reset) begin
            diagCap_r <= 1'b0;
            diagEn_r <= 8'h00;
            extEn_r <= 8'h00;
            diagOld_r <= 8'h00;
            extOld_r <= 8'h00;
            lastOut_r <= 8'h00;
        end else begin
            if (write && !waitrequest && address == 8'h00) begin
                diagCap_r <= writedata[0];
            end
            if (inTake) begin
                diagEn_r <= recData[7:0];
                extEn_r <= recData[15:8];
            end
            if (outValid) begin
                lastOut_r <= outData;
            end
            diagOld_r <= diagEn_r;
            extOld_r <= extEn_r;
        end
    end

    // all checks run on the core clock and rest while reset is high
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    bus_answer_a: assert property (
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("bus answer not one cycle");
    rec_done_a: assert property (recValid |=> recDone)
        else $error("record not answered");
    acc_pair_a: assert property (recAccepted |-> recDone)
        else $error("accept without done");
    in_refuse_a: assert property (
        recValid && !recToOutput && !diagCap_r |=> recDone && !recAccepted)
        else $error("input record taken without capability");
    in_take_a: assert property (inTake |=> recAccepted)
        else $error("input record refused");
    out_take_a: assert property (
        recValid && recToOutput && recIndex == 16'h4000 |=> recAccepted)
        else $error("output record refused");
    bad_index_a: assert property (
        recValid && recIndex != 16'h4000 |=> !recAccepted)
        else $error("wrong index taken");
    alarm_gate_a: assert property (alarmValid |-> enAny[alarmChan])
        else $error("alarm on disabled channel");
    ext_gate_a: assert property (
        alarmValid && alarmExternal |-> extAny[alarmChan] && enAny[alarmChan])
        else $error("external alarm not gated");
    resume_out_a: assert property (
        outValid && run ##1 outValid && run |-> ##[1:3] outPins == lastOut_r)
        else $error("process value not resumed");
endmodule // channel_param_io_props

bind channel_param_io channel_param_io_props props_u (
    .core_clk, .reset, .address, .read, .write, .writedata, .waitrequest,
    .recValid, .recIndex, .recToOutput, .recData, .recDone, .recAccepted,
    .assocUp, .providerRun, .outValid, .outData, .outPins,
    .alarmValid, .alarmChan, .alarmExternal
);
`default_nettype wire

// ### tb/record_controller.sv
`timescale 1ns/1ps
`default_nettype none
module record_controller (
    // clock
    input wire logic core_clk,
    // record write request
    output logic recValid,
    output logic [15:0] recIndex,
    output logic recToOutput,
    output logic [23:0] recData,
    // association and process data
    output logic assocUp,
    output logic providerRun,
    output logic outValid,
    output logic [7:0] outData
);
    // idle, no association, before the first request
    initial begin
        recValid = 1'b0;
        recIndex = 16'h0000;
        recToOutput = 1'b0;
        recData = 24'h000000;
        assocUp = 1'b0;
        providerRun = 1'b0;
        outValid = 1'b0;
        outData = 8'h00;
    end

    // one record write, index chosen by the caller
    task automatic sendRecord(input logic [15:0] idx, input logic toOut,
        input logic [23:0] data);
        @(posedge core_clk);
        recValid <= 1'b1;
        recIndex <= idx;
        recToOutput <= toOut;
        recData <= data;
        @(posedge core_clk);
        recValid <= 1'b0;
        recIndex <= ~idx; // released lines carry no stale value
        recData <= ~data;
    endtask

    // association and provider state
    task automatic setLink(input logic up, input logic runNow);
        @(posedge core_clk);
        assocUp <= up;
        providerRun <= runNow;
    endtask

    // two process values back to back
    task automatic putPair(input logic [7:0] a, input logic [7:0] b);
        @(posedge core_clk);
        outValid <= 1'b1;
        outData <= a;
        @(posedge core_clk);
        outData <= b;
        @(posedge core_clk);
        outValid <= 1'b0;
        outData <= ~b;
    endtask
endmodule // record_controller
`default_nettype wire

// ### tb/tb_channel_param_io.sv
`timescale 1ns/1ps
`default_nettype none
`include "channel_param_defs.svh"
module tb_channel_param_io;
    logic core_clk, reset, read, write, waitrequest;
    logic [7:0] address;
    logic [31:0] writedata, readdata;
    logic [3:0] byteenable;
    logic recValid, recToOutput, recDone, recAccepted;
    logic [15:0] recIndex;
    logic [23:0] recData;
    logic assocUp, providerRun, outValid, alarmValid, alarmExternal;
    logic [7:0] outData, outPins, inPins, chanErrPins, extFaultPins, inReport;
    logic [2:0] alarmChan;
    int errCount = 0;
    int nCompared = 0;
    int alarmSeen = 0;

    channel_param_io dut_u (.core_clk, .reset, .address, .read, .write,
        .writedata, .byteenable, .readdata, .waitrequest, .recValid, .recIndex,
        .recToOutput, .recData, .recDone, .recAccepted, .assocUp,
        .providerRun, .outValid, .outData, .outPins, .inPins, .chanErrPins,
        .extFaultPins, .inReport, .alarmValid, .alarmChan, .alarmExternal);
    record_controller ctrl_u (.core_clk, .recValid, .recIndex, .recToOutput,
        .recData, .assocUp, .providerRun, .outValid, .outData);

    // clock and alarm counter
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (alarmValid === 1'b1) alarmSeen++;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one bus access, held until waitrequest is seen low
    task automatic bus(input logic [7:0] a, input logic wr,
        input logic [31:0] d, output logic [31:0] q);
        int n = 0;
        @(posedge core_clk);
        address <= a;
        write <= wr;
        read <= !wr;
        writedata <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        q = readdata;
        if (n >= 50) chk(32'h1, 32'h0);
        read <= 1'b0;
        write <= 1'b0;
    endtask

    // level driven while output data is missing
    function automatic logic [7:0] expOut(channel_param_pkg::policy_t p,
        logic [7:0] sub, logic [7:0] last, logic hold);
        if (p == channel_param_pkg::POL_KEEP) return last;
        if (p == channel_param_pkg::POL_SUBST) return sub;
        return hold ? last : 8'h00;
    endfunction

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        #200000;
        errCount++;
        tally_and_finish;
    end

    initial begin
        logic [31:0] q;
        logic [23:0] inP;
        logic [15:0] idx;
        logic [7:0] sub, a, b, pins, want;
        channel_param_pkg::policy_t pol;
        channel_param_pkg::policy_t pols[4] = '{channel_param_pkg::POL_KEEP,
            channel_param_pkg::POL_SUBST, channel_param_pkg::POL_DEVICE,
            channel_param_pkg::policy_t'(2'h3)};
        core_clk = 1'b0;
        reset = 1'b1;
        {read, write, address, writedata} = 42'h0;
        byteenable = 4'hF;
        {inPins, chanErrPins, extFaultPins} = 24'h0;
        void'($urandom(15999));
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        // reset values and an unmapped place
        bus(`REG_CTRL, 1'b0, 32'h0, q);
        chk(q, 32'h0);
        bus(`REG_STATUS, 1'b0, 32'h0, q);
        chk(q, 32'h4);
        bus(8'h14, 1'b0, 32'h0, q);
        chk(q, 32'h0);
        chk(outPins, 32'h0);
        $display("test reset done");
        // input record without capability, then W1C clear
        ctrl_u.sendRecord(`REC_INDEX, 1'b0, 24'($urandom));
        #1 chk(recAccepted, 32'h0);
        bus(`REG_STATUS, 1'b0, 32'h0, q);
        chk(q, 32'h5);
        bus(`REG_STATUS, 1'b1, 32'h1, q);
        bus(`REG_STATUS, 1'b0, 32'h0, q);
        chk(q, 32'h4);
        $display("test no capability done");
        // capable module: wrong index refused, right index taken
        bus(`REG_CTRL, 1'b1, 32'h1, q);
        idx = 16'($urandom);
        if (idx == `REC_INDEX) idx = idx ^ 16'h0001;
        ctrl_u.sendRecord(idx, 1'b0, 24'($urandom));
        #1 chk(recAccepted, 32'h0);
        inP = 24'($urandom);
        ctrl_u.sendRecord(`REC_INDEX, 1'b0, inP);
        #1 chk(recAccepted, 32'h1);
        bus(`REG_IN_PARAM, 1'b1, 32'hFFFFFFFF, q);
        bus(`REG_IN_PARAM, 1'b0, 32'h0, q);
        chk(q, {8'h00, inP});
        $display("test input record done");
        // reported level follows the invert bits
        repeat (4) begin
            pins = 8'($urandom);
            inPins <= pins;
            repeat (5) @(posedge core_clk);
            chk(inReport, {24'h0, pins ^ inP[23:16]});
        end
        $display("test invert done");
        // faults on all channels, partly enabled
        ctrl_u.sendRecord(`REC_INDEX, 1'b0, 24'h00330F);
        chanErrPins <= 8'hFF;
        extFaultPins <= 8'hFF;
        repeat (30) @(posedge core_clk);
        chk(alarmSeen, 32'd6);
        bus(`REG_LOG, 1'b0, 32'h0, q);
        chk(q, 32'h00090006);
        chanErrPins <= 8'h00;
        extFaultPins <= 8'h00;
        $display("test alarms done");
        // each missing-data policy, stop or dropped association
        for (int k = 0; k < 4; k++) begin
            pol = pols[k];
            sub = 8'($urandom);
            a = 8'($urandom);
            b = 8'($urandom);
            bus(`REG_CTRL, 1'b1, {30'h0, k == 3, 1'b1}, q);
            ctrl_u.sendRecord(`REC_INDEX, 1'b1, {8'h00, sub, 6'h00, pol});
            #1 chk(recAccepted, 32'h1);
            bus(`REG_OUT_PARAM, 1'b0, 32'h0, q);
            chk(q, {16'h0, sub, 6'h00, pol});
            ctrl_u.setLink(1'b1, 1'b1);
            ctrl_u.putPair(a, b);
            repeat (4) @(posedge core_clk);
            chk(outPins, {24'h0, b});
            ctrl_u.setLink(k != 2, k == 2);
            repeat (5) @(posedge core_clk);
            want = expOut(pol, sub, b, k == 3);
            chk(outPins, {24'h0, want});
        end
        $display("test output policy done");
        tally_and_finish;
    end
endmodule // tb_channel_param_io
`default_nettype wire
